// >>> rtl/sre_hex_char.sv
// Nibble to upper-case hexadecimal character
`timescale 1ns/1ps
module sre_hex_char (
    input wire logic [3:0] nibble_i,
    output logic [7:0] ascii_o
);
    always_comb begin
        if ({4'h0, nibble_i} < sre_pkg::HEX_TEN) begin
            ascii_o = sre_pkg::CHAR_ZERO + {4'h0, nibble_i}; // [R14]
        end else begin
            ascii_o = sre_pkg::CHAR_UPPER_A + {4'h0, nibble_i} - sre_pkg::HEX_TEN; // [R14]
        end
    end
endmodule : sre_hex_char

// >>> rtl/sre_pkg.sv
// Constants and types shared by the status response encoder
package sre_pkg;
    localparam int APB_AW = 12;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_LIVE = 12'h004;
    localparam logic [11:0] OFF_INT_STATUS = 12'h008;
    localparam logic [11:0] OFF_INT_MASK = 12'h00c;
    localparam logic [11:0] OFF_LATCH = 12'h010;

    localparam int CTRL_EN = 0;
    localparam int CTRL_REQ_SYS = 1;
    localparam int CTRL_REQ_ILK = 2;
    localparam logic CTRL_EN_RESET = 1'b1;

    localparam int N_EV = 4;
    localparam int EV_ARC = 0;
    localparam int EV_TAKEOVER = 1;
    localparam int EV_ILLEGAL = 2;
    localparam int EV_DONE = 3;
    localparam logic [3:0] MASK_RESET = 4'h0;

    localparam int LIVE_ILK_LSB = 16;

    // Synchronised pin positions
    localparam int N_PINS = 22;
    localparam int P_ESTOP = 0;
    localparam int P_USER_OFF = 1;
    localparam int P_WATER = 2;
    localparam int P_VACUUM = 3;
    localparam int P_AUX = 4;
    localparam int P_KEY_OFF = 5;
    localparam int P_BUS_LOW = 6;
    localparam int P_BUS_HIGH = 7;
    localparam int P_SOFTSTART = 8;
    localparam int P_SETPT_SHUT = 9;
    localparam int P_HS_UNLINKED = 10;
    localparam int P_RAMP_PAUSED = 11;
    localparam int P_ARC = 12;
    localparam int P_RAMP_ACTIVE = 13;
    localparam int P_PLASMA = 14;
    localparam int P_SETPT_REACHED = 15;
    localparam int P_OUTPUT_ON = 16;
    localparam int P_ILK_OPEN = 17;
    localparam int P_RUN_OVER = 18;
    localparam int P_TARGET_LIMIT = 19;
    localparam int P_METHOD_LSB = 20;

    localparam logic [1:0] METHOD_POWER = 2'h2;
    localparam logic [1:0] METHOD_CURRENT = 2'h1;
    localparam logic [1:0] METHOD_VOLTAGE = 2'h3;

    localparam logic [7:0] CHAR_ZERO = 8'h30;
    localparam logic [7:0] CHAR_UPPER_A = 8'h41;
    localparam logic [7:0] CHAR_NINE = 8'h39;
    localparam logic [7:0] CHAR_UPPER_F = 8'h46;
    localparam logic [7:0] HEX_TEN = 8'h0a;
    localparam logic [7:0] CHAR_SYS = 8'h53;
    localparam logic [7:0] CHAR_ILK = 8'h4b;
    localparam logic [2:0] LAST_IDX = 3'h4;

    typedef enum logic [2:0] {
        SRE_IDLE = 3'b001,
        SRE_LOAD = 3'b010,
        SRE_SEND = 3'b100
    } sre_state_t;
endpackage : sre_pkg

// >>> rtl/sre_status_encoder.sv
// Status reply encoder: condition capture, reply sequencer, APB registers
//
// Behaviour
// [R1] System reply: four hex characters, then letter
// [R2] Interlock char two bit0: key switch off
// [R3] Interlock char three bit3: bus voltage low
// [R4] Interlock char three bit2: bus voltage high
// [R5] Interlock char four: softstart, shutdown, interlock summary
// [R6] System char one bits3-2: regulation method
// [R7] System char one bit1: ramp paused
// [R8] Arc latched until system reply answered
// [R9] System char two: ramp, plasma, reached, on
// [R10] System char three bit3: output turned on
// [R11] System char three bit2: interlock, takeover, runtime
// [R12] System char three: target limit, illegal command
// [R13] System char four: control ownership bits
// [R14] Nibble sent as hex character, upper case
// [R15] Interlock char one: estop, off, water, vacuum
// [R16] Not-applicable bits always zero
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module sre_status_encoder (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic estop_i,
    input wire logic user_off_i,
    input wire logic water_unmet_i,
    input wire logic vacuum_unmet_i,
    input wire logic aux_unmet_i,
    input wire logic key_off_i,
    input wire logic bus_low_i,
    input wire logic bus_high_i,
    input wire logic softstart_fail_i,
    input wire logic setpoint_shutdown_i,
    input wire logic handshake_unlinked_i,
    input wire logic ramp_paused_i,
    input wire logic arc_i,
    input wire logic ramp_active_i,
    input wire logic plasma_i,
    input wire logic setpoint_reached_i,
    input wire logic output_on_i,
    input wire logic interlock_open_i,
    input wire logic run_time_over_i,
    input wire logic target_limit_i,
    input wire logic [1:0] reg_method_i,
    input wire logic host_remote_i,
    input wire logic user_setpoint_i,
    input wire logic user_ramp_i,
    input wire logic user_onoff_i,
    input wire logic system_status_request_i,
    input wire logic interlock_status_request_i,
    input wire logic host_takeover_command_i,
    input wire logic host_latch_clear_command_i,
    input wire logic illegal_command_i,
    input wire logic char_ready_i,
    output logic [7:0] char_o,
    output logic char_valid_o,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o
);
    logic [sre_pkg::N_PINS-1:0] pins_raw;
    logic [sre_pkg::N_PINS-1:0] pins_meta;
    logic [sre_pkg::N_PINS-1:0] pins_s;
    sre_pkg::sre_state_t state;
    logic [2:0] idx;
    logic [15:0] snap_word;
    logic snap_sys;
    logic arc_latch;
    logic arc_during;
    logic seen_on_latch;
    logic takeover_latch;
    logic illegal_latch;
    logic done_q;
    logic reply_en;
    logic sw_req_sys;
    logic sw_req_ilk;
    logic [sre_pkg::N_EV-1:0] int_status;
    logic [sre_pkg::N_EV-1:0] int_mask;
    logic [sre_pkg::N_EV-1:0] ev;
    logic [15:0] sys_word;
    logic [15:0] ilk_word;
    logic [3:0] cur_nibble;
    logic [7:0] hex_char;
    logic [7:0] next_char;
    logic hw_unmet;
    logic req_sys;
    logic req_ilk;
    logic accept;
    logic last_hs;
    logic apb_setup;
    logic apb_wr;
    logic mapped;
    logic [31:0] rd_mux;

    assign pins_raw = {reg_method_i, target_limit_i, run_time_over_i, interlock_open_i,
                       output_on_i, setpoint_reached_i, plasma_i, ramp_active_i, arc_i,
                       ramp_paused_i, handshake_unlinked_i, setpoint_shutdown_i,
                       softstart_fail_i, bus_high_i, bus_low_i, key_off_i, aux_unmet_i,
                       vacuum_unmet_i, water_unmet_i, user_off_i, estop_i};

    // Pins are asynchronous to the clock
    for (genvar g = 0; g < sre_pkg::N_PINS; g++) begin : g_sync
        always_ff @(posedge clock_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                pins_meta[g] <= 1'b0;
                pins_s[g] <= 1'b0;
            end else begin
                pins_meta[g] <= pins_raw[g];
                pins_s[g] <= pins_meta[g];
            end
        end
    end

    assign hw_unmet = pins_s[sre_pkg::P_ESTOP] | pins_s[sre_pkg::P_WATER]
                    | pins_s[sre_pkg::P_VACUUM] | pins_s[sre_pkg::P_AUX];

    // Interlock reply nibbles, first character in the top bits
    assign ilk_word = {pins_s[sre_pkg::P_ESTOP], pins_s[sre_pkg::P_USER_OFF],
                       pins_s[sre_pkg::P_WATER], pins_s[sre_pkg::P_VACUUM], // [R15]
                       pins_s[sre_pkg::P_AUX], 2'h0, pins_s[sre_pkg::P_KEY_OFF], // [R2] [R16]
                       pins_s[sre_pkg::P_BUS_LOW], pins_s[sre_pkg::P_BUS_HIGH], // [R3] [R4]
                       2'h0, // [R16]
                       pins_s[sre_pkg::P_SOFTSTART], pins_s[sre_pkg::P_SETPT_SHUT], 1'b0,
                       hw_unmet | takeover_latch | pins_s[sre_pkg::P_HS_UNLINKED]
                       | pins_s[sre_pkg::P_BUS_LOW]}; // [R5]

    assign sys_word = {pins_s[sre_pkg::P_METHOD_LSB+1], pins_s[sre_pkg::P_METHOD_LSB], // [R6]
                       pins_s[sre_pkg::P_RAMP_PAUSED], arc_latch, // [R7] [R8]
                       pins_s[sre_pkg::P_RAMP_ACTIVE], pins_s[sre_pkg::P_PLASMA],
                       ~pins_s[sre_pkg::P_RAMP_ACTIVE] & pins_s[sre_pkg::P_SETPT_REACHED],
                       pins_s[sre_pkg::P_OUTPUT_ON], // [R9]
                       seen_on_latch, // [R10]
                       pins_s[sre_pkg::P_ILK_OPEN] | takeover_latch
                       | pins_s[sre_pkg::P_RUN_OVER], // [R11]
                       pins_s[sre_pkg::P_TARGET_LIMIT], illegal_latch, // [R12]
                       host_remote_i, user_setpoint_i, user_ramp_i, user_onoff_i}; // [R13]

    assign req_sys = system_status_request_i | sw_req_sys;
    assign req_ilk = interlock_status_request_i | sw_req_ilk;
    // Requests while a reply is under way are dropped, not queued
    assign accept = (state == sre_pkg::SRE_IDLE) & reply_en & (req_sys | req_ilk);
    assign last_hs = (state == sre_pkg::SRE_SEND) & char_ready_i & (idx == sre_pkg::LAST_IDX);

    always_comb begin
        unique case (idx)
            3'h0: cur_nibble = snap_word[15:12];
            3'h1: cur_nibble = snap_word[11:8];
            3'h2: cur_nibble = snap_word[7:4];
            3'h3: cur_nibble = snap_word[3:0];
            default: cur_nibble = 4'h0;
        endcase
    end

    sre_hex_char u_hex (
        .nibble_i(cur_nibble),
        .ascii_o(hex_char)
    );

    always_comb begin
        if (idx == sre_pkg::LAST_IDX) begin
            next_char = snap_sys ? sre_pkg::CHAR_SYS : sre_pkg::CHAR_ILK; // [R1]
        end else begin
            next_char = hex_char; // [R14]
        end
    end

    // Reply sequencer
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= sre_pkg::SRE_IDLE;
            idx <= 3'h0;
            snap_word <= 16'h0000;
            snap_sys <= 1'b0;
            char_o <= 8'h00;
            char_valid_o <= 1'b0;
        end else begin
            unique case (state)
                sre_pkg::SRE_IDLE: begin
                    if (accept) begin
                        // System request wins when both arrive together
                        snap_sys <= req_sys;
                        snap_word <= req_sys ? sys_word : ilk_word; // [R1]
                        idx <= 3'h0;
                        state <= sre_pkg::SRE_LOAD;
                    end
                end
                sre_pkg::SRE_LOAD: begin
                    char_o <= next_char; // [R1]
                    char_valid_o <= 1'b1;
                    state <= sre_pkg::SRE_SEND;
                end
                sre_pkg::SRE_SEND: begin
                    if (char_ready_i) begin
                        char_valid_o <= 1'b0;
                        if (idx == sre_pkg::LAST_IDX) begin
                            state <= sre_pkg::SRE_IDLE;
                        end else begin
                            idx <= idx + 3'h1;
                            state <= sre_pkg::SRE_LOAD;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= last_hs;
        end
    end

    // Arc latch; an arc after the snapshot survives the clear
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            arc_latch <= 1'b0;
            arc_during <= 1'b0;
        end else begin
            if (pins_s[sre_pkg::P_ARC]) begin
                arc_latch <= 1'b1; // [R8]
            end else if (done_q & snap_sys & ~arc_during) begin
                arc_latch <= 1'b0; // [R8]
            end
            if (accept) begin
                // An arc at the snapshot edge misses the reply, so keep it
                arc_during <= pins_s[sre_pkg::P_ARC];
            end else if (pins_s[sre_pkg::P_ARC]) begin
                arc_during <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            seen_on_latch <= 1'b0;
            illegal_latch <= 1'b0;
        end else begin
            if (pins_s[sre_pkg::P_OUTPUT_ON]) begin
                seen_on_latch <= 1'b1; // [R10]
            end else if (done_q & snap_sys) begin
                seen_on_latch <= 1'b0;
            end
            if (illegal_command_i) begin
                illegal_latch <= 1'b1; // [R12]
            end else if (done_q & snap_sys) begin
                illegal_latch <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            takeover_latch <= 1'b0;
        end else if (host_takeover_command_i) begin
            takeover_latch <= 1'b1; // [R5] [R11]
        end else if (host_latch_clear_command_i) begin
            takeover_latch <= 1'b0; // [R5]
        end
    end

    // APB slave, one wait-free access phase
    assign apb_setup = psel_i & ~penable_i;
    assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;
    assign mapped = (paddr_i == sre_pkg::OFF_CTRL) | (paddr_i == sre_pkg::OFF_LIVE)
                  | (paddr_i == sre_pkg::OFF_INT_STATUS) | (paddr_i == sre_pkg::OFF_INT_MASK)
                  | (paddr_i == sre_pkg::OFF_LATCH);

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr_i == sre_pkg::OFF_CTRL) begin
            rd_mux[sre_pkg::CTRL_EN] = reply_en;
        end else if (paddr_i == sre_pkg::OFF_LIVE) begin
            rd_mux = {ilk_word, sys_word};
        end else if (paddr_i == sre_pkg::OFF_INT_STATUS) begin
            rd_mux[sre_pkg::N_EV-1:0] = int_status;
        end else if (paddr_i == sre_pkg::OFF_INT_MASK) begin
            rd_mux[sre_pkg::N_EV-1:0] = int_mask;
        end else if (paddr_i == sre_pkg::OFF_LATCH) begin
            rd_mux[3:0] = {seen_on_latch, illegal_latch, takeover_latch, arc_latch};
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= apb_setup;
            pslverr_o <= apb_setup & ~mapped;
            prdata_o <= (apb_setup & ~pwrite_i) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reply_en <= sre_pkg::CTRL_EN_RESET;
            sw_req_sys <= 1'b0;
            sw_req_ilk <= 1'b0;
            int_mask <= sre_pkg::MASK_RESET;
        end else begin
            sw_req_sys <= apb_wr & (paddr_i == sre_pkg::OFF_CTRL) & pwdata_i[sre_pkg::CTRL_REQ_SYS];
            sw_req_ilk <= apb_wr & (paddr_i == sre_pkg::OFF_CTRL) & pwdata_i[sre_pkg::CTRL_REQ_ILK];
            if (apb_wr & (paddr_i == sre_pkg::OFF_CTRL)) begin
                reply_en <= pwdata_i[sre_pkg::CTRL_EN];
            end
            if (apb_wr & (paddr_i == sre_pkg::OFF_INT_MASK)) begin
                int_mask <= pwdata_i[sre_pkg::N_EV-1:0];
            end
        end
    end

    // Every sensed arc is an event, even while the reply latch is already set
    assign ev = {done_q, illegal_command_i, host_takeover_command_i,
                 pins_s[sre_pkg::P_ARC]};

    // Set beats a same-cycle write-one clear
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            int_status <= '0;
            irq_o <= 1'b0;
        end else begin
            if (apb_wr & (paddr_i == sre_pkg::OFF_INT_STATUS)) begin
                int_status <= (int_status & ~pwdata_i[sre_pkg::N_EV-1:0]) | ev;
            end else begin
                int_status <= int_status | ev;
            end
            irq_o <= |(int_status & int_mask);
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence seq_accept_sys;
        accept && req_sys;
    endsequence

    sequence seq_first_char;
        ##1 (state == sre_pkg::SRE_LOAD) ##1 char_valid_o;
    endsequence

    AST_REPLY_START: assert property (seq_accept_sys |-> seq_first_char) // [R1]
        else $error("System reply did not start two cycles after accept");

    AST_REPLY_LETTER: assert property (char_valid_o && idx == sre_pkg::LAST_IDX
            |-> char_o == (snap_sys ? sre_pkg::CHAR_SYS : sre_pkg::CHAR_ILK)) // [R1]
        else $error("Fifth reply character is not the command letter");

    AST_HEX_RANGE: assert property (char_valid_o && idx < sre_pkg::LAST_IDX
            |-> (char_o >= sre_pkg::CHAR_ZERO && char_o <= sre_pkg::CHAR_NINE)
             || (char_o >= sre_pkg::CHAR_UPPER_A && char_o <= sre_pkg::CHAR_UPPER_F)) // [R14]
        else $error("Status character is not an upper-case hex digit");

    AST_METHOD: assert property (seq_accept_sys
            |=> snap_word[15:14] == $past(pins_s[sre_pkg::P_METHOD_LSB+1:sre_pkg::P_METHOD_LSB]))
        // [R6]
        else $error("Regulation method bits not captured");

    AST_KEY_OFF: assert property (accept && !req_sys
            |=> snap_word[8] == $past(pins_s[sre_pkg::P_KEY_OFF])) // [R2]
        else $error("Key switch bit wrong in interlock reply");

    AST_BUS_LIMITS: assert property (accept && !req_sys
            |=> snap_word[7:6] == $past({pins_s[sre_pkg::P_BUS_LOW],
                                          pins_s[sre_pkg::P_BUS_HIGH]})) // [R3] [R4]
        else $error("Bus voltage bits wrong in interlock reply");

    AST_ILK_SUMMARY: assert property (accept && !req_sys && takeover_latch
            |=> snap_word[0]) // [R5]
        else $error("Interlock summary bit missing after takeover");

    AST_ARC_SET: assert property (pins_s[sre_pkg::P_ARC] |=> arc_latch[*2]) // [R8]
        else $error("Arc not latched");

    AST_ARC_HOLD: assert property (arc_latch && !done_q |=> arc_latch) // [R8]
        else $error("Arc latch dropped before a system reply ended");

    AST_NA_ZERO: assert property (!snap_sys && state != sre_pkg::SRE_IDLE
            |-> snap_word[10:9] == 2'h0 && snap_word[5:4] == 2'h0 && !snap_word[1]) // [R16]
        else $error("Not-applicable interlock bit set");

    AST_TAKEOVER: assert property (host_takeover_command_i |=> takeover_latch ##1
            (takeover_latch || $past(host_latch_clear_command_i))) // [R11]
        else $error("Takeover latch lost without a clear command");
endmodule : sre_status_encoder

// >>> tb/sre_host_model.sv
// Host side consumer of reply characters, prompt or stalling
`timescale 1ns/1ps
module sre_host_model (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic slow_i,
    output logic char_ready_o
);
    logic [1:0] cnt;
    // Slow host takes one cycle in four, so every char after the first of a reply waits
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= 2'h0;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
    assign char_ready_o = slow_i ? (cnt == 2'h3) : 1'b1;
endmodule : sre_host_model

// >>> tb/tb.sv
// Self-checking bench for the status reply encoder
`timescale 1ns/1ps
module tb;
    logic clock_i, sys_rst_i, sreq, ireq, tko, lclr, ill, slow, psel, penable, pwrite;
    logic [25:0] lv, nl;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, r, st;
    logic pready, pslverr, irq, cval, rdy, er, arc_l, seen_l, ill_l, tk_l, sysreq;
    logic [7:0] ch;
    logic [15:0] sw, iw;
    logic [7:0] q[$];
    int err_count, compares, i, k, n;

    sre_status_encoder uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .estop_i(lv[0]), .user_off_i(lv[1]), .water_unmet_i(lv[2]), .vacuum_unmet_i(lv[3]),
        .aux_unmet_i(lv[4]), .key_off_i(lv[5]), .bus_low_i(lv[6]), .bus_high_i(lv[7]),
        .softstart_fail_i(lv[8]), .setpoint_shutdown_i(lv[9]), .handshake_unlinked_i(lv[10]),
        .ramp_paused_i(lv[11]), .arc_i(lv[12]), .ramp_active_i(lv[13]), .plasma_i(lv[14]),
        .setpoint_reached_i(lv[15]), .output_on_i(lv[16]), .interlock_open_i(lv[17]),
        .run_time_over_i(lv[18]), .target_limit_i(lv[19]), .reg_method_i(lv[21:20]),
        .host_remote_i(lv[22]), .user_setpoint_i(lv[23]), .user_ramp_i(lv[24]),
        .user_onoff_i(lv[25]), .system_status_request_i(sreq),
        .interlock_status_request_i(ireq), .host_takeover_command_i(tko),
        .host_latch_clear_command_i(lclr), .illegal_command_i(ill), .char_ready_i(rdy),
        .char_o(ch), .char_valid_o(cval), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq));
    sre_host_model host (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
        .char_ready_o(rdy));

    function automatic logic [31:0] xs();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction : xs

    function automatic logic [7:0] hx(input logic [3:0] v);
        return (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h41 + {4'h0, v} - 8'h0a;
    endfunction : hx

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        // The wait ends when pready is seen; the watchdog ends it only if pready never comes
        do begin
            @(posedge clock_i);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse_sys();
        @(posedge clock_i);
        sreq <= 1'b1;
        @(posedge clock_i);
        sreq <= 1'b0;
    endtask : pulse_sys

    task automatic test_done();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    // Reply monitor: each taken char against the oldest note
    always @(posedge clock_i) begin
        if (cval === 1'b1 && rdy === 1'b1) begin
            if (q.size() == 0) begin
                err_count++;
                $display("MISMATCH t=%0t char without request", $time);
            end else begin
                chk({24'h0, ch}, {24'h0, q.pop_front()});
            end
        end
    end

    initial begin
        repeat (60000) @(posedge clock_i);
        err_count++;
        test_done();
    end

    initial begin
        sys_rst_i = 1'b1;
        lv = '0;
        {sreq, ireq, tko, lclr, ill, slow, psel, penable, pwrite} = '0;
        paddr = '0;
        pwdata = '0;
        st = 32'h0000_2796;
        {arc_l, seen_l, ill_l, tk_l} = '0;
        err_count = 0;
        compares = 0;
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        apb(1'b0, sre_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        $display("test registers done");
        for (i = 0; i < 40; i++) begin
            r = xs();
            nl = r[25:0];
            if (nl[21:20] == 2'h0) nl[21:20] = sre_pkg::METHOD_VOLTAGE;
            @(posedge clock_i);
            lv <= nl;
            tko <= r[26] & r[27];
            lclr <= r[28];
            ill <= r[29] & r[27];
            slow <= r[30];
            arc_l = arc_l | nl[12];
            seen_l = seen_l | nl[16];
            ill_l = ill_l | (r[29] & r[27]);
            tk_l = (r[26] & r[27]) ? 1'b1 : (r[28] ? 1'b0 : tk_l);
            @(posedge clock_i);
            lv[12] <= 1'b0;
            {tko, lclr, ill} <= 3'h0;
            repeat (4) @(posedge clock_i);
            sw = {nl[21:20], nl[11], arc_l, nl[13], nl[14], nl[15] & ~nl[13], nl[16],
                  seen_l, nl[17] | tk_l | nl[18], nl[19], ill_l,
                  nl[22], nl[23], nl[24], nl[25]};
            iw = {nl[0], nl[1], nl[2], nl[3], nl[4], 2'h0, nl[5], nl[6], nl[7], 2'h0,
                  nl[8], nl[9], 1'b0, |{nl[0], nl[2], nl[3], nl[4], tk_l, nl[10], nl[6]}};
            apb(1'b0, sre_pkg::OFF_LIVE, 32'h0);
            chk(rd, {iw, sw});
            r = xs();
            sysreq = (r[1:0] != 2'h1) && !(r[1:0] == 2'h3 && r[2]);
            for (k = 3; k >= 0; k--) q.push_back(hx(sysreq ? sw[4*k+:4] : iw[4*k+:4]));
            q.push_back(sysreq ? sre_pkg::CHAR_SYS : sre_pkg::CHAR_ILK);
            if (r[1:0] == 2'h3) begin
                apb(1'b1, sre_pkg::OFF_CTRL, r[2] ? 32'h5 : 32'h3);
            end else begin
                @(posedge clock_i);
                sreq <= (r[1:0] != 2'h1);
                ireq <= (r[1:0] != 2'h0);
                @(posedge clock_i);
                {sreq, ireq} <= 2'h0;
            end
            if (r[3]) begin
                repeat (4) @(posedge clock_i);
                pulse_sys();
            end
            n = 0;
            while (q.size() != 0 && n < 400) begin
                @(posedge clock_i);
                n++;
            end
            chk(q.size(), 0);
            repeat (3) @(posedge clock_i);
            // Arc and illegal latches drop after a system reply; output-seen reloads from the output pin
            if (sysreq) begin
                arc_l = 1'b0;
                seen_l = nl[16];
                ill_l = 1'b0;
            end
        end
        chk(q.size(), 0);
        $display("test replies done");
        apb(1'b1, sre_pkg::OFF_INT_MASK, 32'h8);
        repeat (2) @(posedge clock_i);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, sre_pkg::OFF_INT_STATUS, 32'hf);
        repeat (2) @(posedge clock_i);
        chk({31'h0, irq}, 32'h0);
        @(posedge clock_i);
        lv[12] <= 1'b1;
        @(posedge clock_i);
        lv[12] <= 1'b0;
        repeat (4) @(posedge clock_i);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, sre_pkg::OFF_INT_STATUS, 32'h0);
        chk({31'h0, rd[0]}, 32'h1);
        apb(1'b1, sre_pkg::OFF_INT_MASK, 32'h1);
        repeat (2) @(posedge clock_i);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, sre_pkg::OFF_INT_STATUS, 32'h1);
        repeat (2) @(posedge clock_i);
        chk({31'h0, irq}, 32'h0);
        $display("test interrupts done");
        apb(1'b1, sre_pkg::OFF_CTRL, 32'h0);
        pulse_sys();
        repeat (10) @(posedge clock_i);
        chk({31'h0, cval}, 32'h0);
        apb(1'b0, sre_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        $display("test disable done");
        test_done();
    end
endmodule : tb
